// file: aio_alarm_pkg.sv
// Package with register map, reset values and carrier types for the analog I/O alarm register bank.
package aio_alarm_pkg;
	localparam logic [15:0] OFS_VERSION_AND_TYPE = 16'h0000;
	localparam logic [15:0] OFS_NODE_ADDRESS = 16'h0001;
	localparam logic [15:0] OFS_LINE_SPEED = 16'h0002;
	localparam logic [15:0] OFS_FRAME_FORMAT = 16'h0003;
	localparam logic [15:0] OFS_PARITY_SELECT = 16'h0004;
	localparam logic [15:0] OFS_REPLY_DELAY = 16'h0005;
	localparam logic [15:0] OFS_PROTOCOL_VARIANT = 16'h0006;
	localparam logic [15:0] OFS_LOWPASS_SETTING = 16'h0009;
	localparam logic [15:0] OFS_RX_COUNT_LOW = 16'h0020;
	localparam logic [15:0] OFS_RX_COUNT_HIGH = 16'h0021;
	localparam logic [15:0] OFS_BAD_RX_COUNT_LOW = 16'h0022;
	localparam logic [15:0] OFS_BAD_RX_COUNT_HIGH = 16'h0023;
	localparam logic [15:0] OFS_TX_COUNT_LOW = 16'h0024;
	localparam logic [15:0] OFS_TX_COUNT_HIGH = 16'h0025;
	localparam logic [15:0] OFS_CONNECTED_INPUTS = 16'h0032;
	localparam logic [15:0] OFS_ALARM_AND_OUTPUT_STATE = 16'h0033;
	localparam logic [15:0] OFS_VOLTAGE_READING = 16'h0034;
	localparam logic [15:0] OFS_CURRENT_READING = 16'h0035;
	localparam logic [15:0] OFS_VOLTAGE_HIGH_THRESHOLD = 16'h0036;
	localparam logic [15:0] OFS_VOLTAGE_LOW_THRESHOLD = 16'h0037;
	localparam logic [15:0] OFS_CURRENT_HIGH_THRESHOLD = 16'h0038;
	localparam logic [15:0] OFS_CURRENT_LOW_THRESHOLD = 16'h0039;
	localparam logic [15:0] OFS_VOLTAGE_ALARM_MODE = 16'h003A;
	localparam logic [15:0] OFS_CURRENT_ALARM_MODE = 16'h003B;
	localparam logic [15:0] OFS_VOLTAGE_RANGE_SELECT = 16'h003C;
	localparam logic [15:0] OFS_CURRENT_RANGE_SELECT = 16'h003D;
	localparam logic [15:0] OFS_OUTPUT_SOURCE_SELECT = 16'h003E;
	localparam logic [15:0] OFS_OUTPUT_THRESHOLD = 16'h003F;
	localparam logic [15:0] OFS_OUTPUT_DEADBAND = 16'h0040;
	localparam logic [15:0] OFS_VOLTAGE_PRESENT_BIT = 16'h0320;
	localparam logic [15:0] OFS_CURRENT_PRESENT_BIT = 16'h0321;
	localparam logic [15:0] OFS_VOLTAGE_ALARM_BIT = 16'h0330;
	localparam logic [15:0] OFS_CURRENT_ALARM_BIT = 16'h0331;
	localparam logic [15:0] OFS_OUTPUT_STATE_BIT = 16'h0332;

	// Field positions in alarm_and_output_state, connected_inputs and out_cfg.
	localparam int POS_VOLTAGE_ALARM = 0;
	localparam int POS_ANY_ALARM = 1;
	localparam int POS_CURRENT_ALARM = 2;
	localparam int POS_OUTPUT = 3;
	localparam int POS_VOLTAGE_PRESENT = 0;
	localparam int POS_CURRENT_PRESENT = 1;
	localparam int POS_COOLING = 8;
	localparam int POS_WARMING = 9;

	localparam logic [15:0] RST_LINE_SPEED = 16'h0003;
	localparam logic [15:0] RST_FRAME_FORMAT = 16'h0108;
	localparam logic [15:0] RST_PARITY_SELECT = 16'h0000;
	localparam logic [15:0] RST_REPLY_DELAY = 16'h0000;
	localparam logic [15:0] RST_PROTOCOL_VARIANT = 16'h0000;
	localparam logic [15:0] RST_LOWPASS_SETTING = 16'h0001;
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] LOWPASS_MIN = 16'h0001;
	localparam logic [15:0] LOWPASS_MAX = 16'h000A;

	// Alarm and range selections.
	localparam logic [15:0] ALARM_LIVE = 16'h0000;
	localparam logic [15:0] ALARM_LATCHED = 16'h0001;
	localparam logic [15:0] CRANGE_OFF = 16'h0000;
	localparam logic [15:0] CRANGE_0_20 = 16'h0001;
	localparam logic [15:0] CRANGE_4_20 = 16'h0002;
	localparam logic [15:0] CRANGE_BIPOLAR = 16'h0003;
	localparam logic [15:0] VRANGE_OFF = 16'h0000;
	localparam logic [15:0] VRANGE_0_10 = 16'h0001;
	localparam logic [15:0] VRANGE_BIPOLAR_10 = 16'h0002;
	localparam logic [15:0] VRANGE_0_1 = 16'h0003;
	localparam logic [15:0] VRANGE_BIPOLAR_1 = 16'h0004;
	localparam logic signed [16:0] LIVE_ZERO_UA = 17'sh00FA0;
	localparam int PERMILLE_SHIFT = 4;

	// Reply delay timing.
	localparam int CLOCK_HZ = 125000000;
	localparam int MS_PER_S = 1000;
	localparam int CYCLES_PER_MS = CLOCK_HZ / MS_PER_S;

	typedef enum logic [7:0] {
		SRC_MASTER = 8'h00,
		SRC_VOLTAGE = 8'h01,
		SRC_CURRENT = 8'h02
	} out_source_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic bit_access;
		logic [15:0] addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [15:0] line_speed;
		logic [15:0] frame_format;
		logic [15:0] parity_select;
		logic [15:0] protocol_variant;
	} comm_config_t;

	typedef struct packed {
		logic rx_frame;
		logic rx_bad_frame;
		logic tx_frame;
	} frame_events_t;
endpackage

// file: analog_io_alarm_register_map.sv
// Register bank, input conditioning, alarms and output logic of the two-input one-output I/O module.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - One low-pass filter setting applies to both inputs together, never to one alone.
// - Filter register accepts 1 to 10; the value sets the filter time constant.
// - Voltage above its high threshold raises alarm bit 1 of the alarm/output register.
// - Voltage below its low threshold raises alarm bit 1 of the alarm/output register.
// - Current above its high threshold raises alarm bit 1 of the alarm/output register.
// - Current below its low threshold raises alarm bit 1 of the alarm/output register.
// - Alarm mode 0 makes alarms follow present readings and clear by themselves.
// - Alarm mode 1 holds a raised alarm until the master clears it by writing.
// - Current range: 0 off, 1 0-20 mA in uA, 2 4-20 mA in per-mille, 3 bipolar uA.
// - Output source low byte: 0 master, 1 voltage reading, 2 current reading.
// - Adding 256 sets the output while the reading exceeds the threshold value.
// - Adding 512 sets the output while the reading is below the threshold value.
// - Bit 3 shows the output; writing it drives the output under master control.
// - An input's connected bit is high while a signal is detected on it and its range is not off.
// - Received, bad and sent frame counts are 32 bits in two writable halves.
// - Each reply waits the number of milliseconds held in the reply delay register.
module analog_io_alarm_register_map #(
	parameter int MS_CYCLES = aio_alarm_pkg::CYCLES_PER_MS,
	parameter logic [15:0] VERSION_CODE = 16'h0101 // Arbitrary identification value.
) (
	input wire logic clock, // System clock, 125 MHz.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire aio_alarm_pkg::reg_req_t reg_req, // Register or bit access from the frame engine.
	output logic [15:0] reg_rdata, // Read data, valid with reg_ack.
	output logic reg_ack, // One-cycle answer to each request.
	input wire logic [7:0] node_address_strap, // Module address switches, caught after reset.
	input wire logic sample_valid, // New raw samples present this cycle.
	input wire logic signed [15:0] voltage_raw, // Raw voltage sample in mV.
	input wire logic signed [15:0] current_raw, // Raw current sample in uA.
	input wire logic voltage_sense_pin, // Voltage input signal-present detector pin.
	input wire logic current_sense_pin, // Current input signal-present detector pin.
	input wire aio_alarm_pkg::frame_events_t frame_events, // One-cycle frame event pulses.
	input wire logic reply_ready, // Pulse: a reply frame is ready to send.
	output logic reply_go, // Pulse: start sending the reply now.
	output aio_alarm_pkg::comm_config_t comm_config, // Line settings for the frame engine.
	output logic digital_out // Digital output drive.
);
	import aio_alarm_pkg::*;

	logic [7:0] node_address;
	logic strap_taken;
	logic [15:0] reply_delay;
	logic [15:0] lowpass_setting;
	logic [31:0] rx_count, bad_rx_count, tx_count;
	logic signed [15:0] volt_hi, volt_lo, curr_hi, curr_lo, out_thr;
	logic [15:0] volt_mode, curr_mode, volt_range, curr_range, out_cfg, deadband;
	logic signed [15:0] voltage_reading, current_reading;
	logic signed [25:0] volt_acc, curr_acc;
	logic volt_alarm, curr_alarm, out_state;
	logic [2:0] vsync, csync;
	logic volt_pin, curr_pin;
	logic [15:0] delay_ms;
	logic [31:0] ms_count;
	logic delay_busy;

	wire wr = reg_req.valid && reg_req.write;
	wire word_wr = wr && !reg_req.bit_access;
	wire bit_wr = wr && reg_req.bit_access;
	wire [15:0] wd = reg_req.wdata;

	function automatic logic word_hit(input logic [15:0] ofs);
		return word_wr && reg_req.addr == ofs;
	endfunction

	function automatic logic bit_hit(input logic [15:0] ofs);
		return bit_wr && reg_req.addr == ofs;
	endfunction

	// The strap is read one cycle after release, never under the asynchronous reset.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			node_address <= 8'h00;
			strap_taken <= 1'b0;
		end else if (!strap_taken) begin
			node_address <= node_address_strap;
			strap_taken <= 1'b1;
		end
	end

	// Communication and configuration registers.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			comm_config.line_speed <= RST_LINE_SPEED;
			comm_config.frame_format <= RST_FRAME_FORMAT;
			comm_config.parity_select <= RST_PARITY_SELECT;
			comm_config.protocol_variant <= RST_PROTOCOL_VARIANT;
			reply_delay <= RST_REPLY_DELAY;
			lowpass_setting <= RST_LOWPASS_SETTING;
			volt_hi <= RST_ZERO;
			volt_lo <= RST_ZERO;
			curr_hi <= RST_ZERO;
			curr_lo <= RST_ZERO;
			volt_mode <= ALARM_LIVE;
			curr_mode <= ALARM_LIVE;
			volt_range <= VRANGE_OFF;
			curr_range <= CRANGE_OFF;
			out_cfg <= RST_ZERO;
			out_thr <= RST_ZERO;
			deadband <= RST_ZERO;
		end else begin
			if (word_hit(OFS_LINE_SPEED)) comm_config.line_speed <= wd;
			if (word_hit(OFS_FRAME_FORMAT)) comm_config.frame_format <= wd;
			if (word_hit(OFS_PARITY_SELECT)) comm_config.parity_select <= wd;
			if (word_hit(OFS_PROTOCOL_VARIANT)) comm_config.protocol_variant <= wd;
			if (word_hit(OFS_REPLY_DELAY)) reply_delay <= wd;
			// Out-of-range settings are dropped so the filter never sees zero or a huge shift.
			if (word_hit(OFS_LOWPASS_SETTING) && wd >= LOWPASS_MIN && wd <= LOWPASS_MAX) begin
				lowpass_setting <= wd;
			end
			if (word_hit(OFS_VOLTAGE_HIGH_THRESHOLD)) volt_hi <= wd;
			if (word_hit(OFS_VOLTAGE_LOW_THRESHOLD)) volt_lo <= wd;
			if (word_hit(OFS_CURRENT_HIGH_THRESHOLD)) curr_hi <= wd;
			if (word_hit(OFS_CURRENT_LOW_THRESHOLD)) curr_lo <= wd;
			if (word_hit(OFS_VOLTAGE_ALARM_MODE)) volt_mode <= wd;
			if (word_hit(OFS_CURRENT_ALARM_MODE)) curr_mode <= wd;
			if (word_hit(OFS_VOLTAGE_RANGE_SELECT)) volt_range <= wd;
			if (word_hit(OFS_CURRENT_RANGE_SELECT)) curr_range <= wd;
			if (word_hit(OFS_OUTPUT_SOURCE_SELECT)) out_cfg <= wd;
			if (word_hit(OFS_OUTPUT_THRESHOLD)) out_thr <= wd;
			if (word_hit(OFS_OUTPUT_DEADBAND)) deadband <= wd;
		end
	end

	// Frame statistics; a master write to a half takes priority over a same-cycle increment.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_count <= 32'h00000000;
			bad_rx_count <= 32'h00000000;
			tx_count <= 32'h00000000;
		end else begin
			if (frame_events.rx_frame) rx_count <= rx_count + 32'h00000001;
			if (frame_events.rx_bad_frame) bad_rx_count <= bad_rx_count + 32'h00000001;
			if (frame_events.tx_frame) tx_count <= tx_count + 32'h00000001;
			if (word_hit(OFS_RX_COUNT_LOW)) rx_count[15:0] <= wd;
			if (word_hit(OFS_RX_COUNT_HIGH)) rx_count[31:16] <= wd;
			if (word_hit(OFS_BAD_RX_COUNT_LOW)) bad_rx_count[15:0] <= wd;
			if (word_hit(OFS_BAD_RX_COUNT_HIGH)) bad_rx_count[31:16] <= wd;
			if (word_hit(OFS_TX_COUNT_LOW)) tx_count[15:0] <= wd;
			if (word_hit(OFS_TX_COUNT_HIGH)) tx_count[31:16] <= wd;
		end
	end

	// Range conversion of the raw samples before filtering.
	logic signed [15:0] volt_scaled, curr_scaled;
	logic signed [16:0] curr_offset;
	always_comb begin
		curr_offset = 17'(current_raw) - LIVE_ZERO_UA;
		case (volt_range)
			VRANGE_0_10, VRANGE_0_1: volt_scaled = voltage_raw[15] ? 16'sh0000 : voltage_raw;
			VRANGE_BIPOLAR_10, VRANGE_BIPOLAR_1: volt_scaled = voltage_raw;
			default: volt_scaled = 16'sh0000;
		endcase
		case (curr_range)
			CRANGE_0_20: curr_scaled = current_raw[15] ? 16'sh0000 : current_raw;
			CRANGE_4_20: curr_scaled = curr_offset[16] ? 16'sh0000 : 16'(curr_offset >>> PERMILLE_SHIFT);
			CRANGE_BIPOLAR: curr_scaled = current_raw;
			default: curr_scaled = 16'sh0000;
		endcase
	end

	// First-order low-pass shared by both inputs: acc moves by (in - acc) / 2^setting.
	// The accumulator keeps eight fraction bits so long time constants still settle.
	wire [3:0] lp_shift = lowpass_setting[3:0];
	wire signed [25:0] volt_step = ((26'(volt_scaled) <<< 8) - volt_acc) >>> lp_shift;
	wire signed [25:0] curr_step = ((26'(curr_scaled) <<< 8) - curr_acc) >>> lp_shift;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			volt_acc <= 26'sh0000000;
			curr_acc <= 26'sh0000000;
			voltage_reading <= 16'sh0000;
			current_reading <= 16'sh0000;
		end else if (sample_valid) begin
			volt_acc <= volt_acc + volt_step;
			curr_acc <= curr_acc + curr_step;
			voltage_reading <= volt_acc[23:8];
			current_reading <= curr_acc[23:8];
		end
	end

	// Detector pins cross from the analog front end; a level counts once stages two and three agree.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			vsync <= 3'h0;
			csync <= 3'h0;
			volt_pin <= 1'b0;
			curr_pin <= 1'b0;
		end else begin
			vsync <= {vsync[1:0], voltage_sense_pin};
			csync <= {csync[1:0], current_sense_pin};
			if (vsync[1] == vsync[2]) volt_pin <= vsync[2];
			if (csync[1] == csync[2]) curr_pin <= csync[2];
		end
	end

	wire volt_present = volt_pin && volt_range != VRANGE_OFF;
	wire curr_present = curr_pin && curr_range != CRANGE_OFF;

	// Threshold conditions with deadband on release.
	wire signed [16:0] db = {1'b0, deadband};
	wire volt_over = voltage_reading > volt_hi;
	wire volt_under = voltage_reading < volt_lo;
	wire curr_over = current_reading > curr_hi;
	wire curr_under = current_reading < curr_lo;
	wire volt_clear = 17'(voltage_reading) <= 17'(volt_hi) - db && 17'(voltage_reading) >= 17'(volt_lo) + db;
	wire curr_clear = 17'(current_reading) <= 17'(curr_hi) - db && 17'(current_reading) >= 17'(curr_lo) + db;

	// A master write of zero clears a latched alarm, but a condition present that cycle wins.
	wire wr_state = word_hit(OFS_ALARM_AND_OUTPUT_STATE);
	wire volt_wr_clr = (wr_state && (!wd[POS_VOLTAGE_ALARM] || !wd[POS_ANY_ALARM]))
		|| (bit_hit(OFS_VOLTAGE_ALARM_BIT) && !wd[0]);
	wire curr_wr_clr = (wr_state && (!wd[POS_CURRENT_ALARM] || !wd[POS_ANY_ALARM]))
		|| (bit_hit(OFS_CURRENT_ALARM_BIT) && !wd[0]);
	wire volt_wr_set = (wr_state && wd[POS_VOLTAGE_ALARM]) || (bit_hit(OFS_VOLTAGE_ALARM_BIT) && wd[0]);
	wire curr_wr_set = (wr_state && wd[POS_CURRENT_ALARM]) || (bit_hit(OFS_CURRENT_ALARM_BIT) && wd[0]);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			volt_alarm <= 1'b0;
			curr_alarm <= 1'b0;
		end else begin
			if (volt_over || volt_under || volt_wr_set) begin
				volt_alarm <= 1'b1;
			end else if (volt_mode == ALARM_LATCHED) begin
				if (volt_wr_clr) volt_alarm <= 1'b0;
			end else if (volt_clear || volt_wr_clr) begin
				volt_alarm <= 1'b0;
			end
			if (curr_over || curr_under || curr_wr_set) begin
				curr_alarm <= 1'b1;
			end else if (curr_mode == ALARM_LATCHED) begin
				if (curr_wr_clr) curr_alarm <= 1'b0;
			end else if (curr_clear || curr_wr_clr) begin
				curr_alarm <= 1'b0;
			end
		end
	end

	// Digital output: master bit or a thermostat on the selected reading.
	out_source_t out_src;
	logic signed [15:0] sel_reading;
	always_comb begin
		out_src = out_source_t'(out_cfg[7:0]);
		case (out_src)
			SRC_VOLTAGE: sel_reading = voltage_reading;
			SRC_CURRENT: sel_reading = current_reading;
			default: sel_reading = 16'sh0000;
		endcase
	end

	wire cooling = out_cfg[POS_COOLING];
	wire warming = out_cfg[POS_WARMING];
	wire signed [16:0] sel17 = 17'(sel_reading);
	wire signed [16:0] thr17 = 17'(out_thr);
	wire master_src = out_src == SRC_MASTER;
	wire out_wr = (wr_state && master_src) || (bit_hit(OFS_OUTPUT_STATE_BIT) && master_src);
	wire out_wr_val = reg_req.bit_access ? wd[0] : wd[POS_OUTPUT];

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			out_state <= 1'b0;
		end else begin
			if (master_src) begin
				if (out_wr) out_state <= out_wr_val;
			end else if (out_src != SRC_VOLTAGE && out_src != SRC_CURRENT) begin
				out_state <= 1'b0;
			end else if (cooling && !warming) begin
				if (sel17 > thr17) out_state <= 1'b1;
				else if (sel17 < thr17 - db) out_state <= 1'b0;
			end else if (warming && !cooling) begin
				if (sel17 < thr17) out_state <= 1'b1;
				else if (sel17 > thr17 + db) out_state <= 1'b0;
			end else begin
				out_state <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) digital_out <= 1'b0;
		else digital_out <= out_state;
	end

	// Reply delay: a millisecond tick is only counted while a reply waits.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			delay_busy <= 1'b0;
			delay_ms <= 16'h0000;
			ms_count <= 32'h00000000;
			reply_go <= 1'b0;
		end else begin
			reply_go <= 1'b0;
			if (reply_ready) begin
				delay_busy <= 1'b1;
				delay_ms <= reply_delay;
				ms_count <= 32'h00000000;
			end else if (delay_busy) begin
				if (delay_ms == 16'h0000) begin
					delay_busy <= 1'b0;
					reply_go <= 1'b1;
				end else if (ms_count == 32'(MS_CYCLES - 1)) begin
					ms_count <= 32'h00000000;
					delay_ms <= delay_ms - 16'h0001;
				end else begin
					ms_count <= ms_count + 32'h00000001;
				end
			end
		end
	end

	// Read mux; unmapped addresses read zero and are still answered.
	logic [15:0] rd;
	wire [15:0] state_word = {12'h000, out_state, curr_alarm, volt_alarm || curr_alarm, volt_alarm};
	always_comb begin
		rd = 16'h0000;
		if (reg_req.bit_access) begin
			case (reg_req.addr)
				OFS_VOLTAGE_PRESENT_BIT: rd = {15'h0000, volt_present};
				OFS_CURRENT_PRESENT_BIT: rd = {15'h0000, curr_present};
				OFS_VOLTAGE_ALARM_BIT: rd = {15'h0000, volt_alarm};
				OFS_CURRENT_ALARM_BIT: rd = {15'h0000, curr_alarm};
				OFS_OUTPUT_STATE_BIT: rd = {15'h0000, out_state};
				default: rd = 16'h0000;
			endcase
		end else begin
			case (reg_req.addr)
				OFS_VERSION_AND_TYPE: rd = VERSION_CODE;
				OFS_NODE_ADDRESS: rd = {8'h00, node_address};
				OFS_LINE_SPEED: rd = comm_config.line_speed;
				OFS_FRAME_FORMAT: rd = comm_config.frame_format;
				OFS_PARITY_SELECT: rd = comm_config.parity_select;
				OFS_REPLY_DELAY: rd = reply_delay;
				OFS_PROTOCOL_VARIANT: rd = comm_config.protocol_variant;
				OFS_LOWPASS_SETTING: rd = lowpass_setting;
				OFS_RX_COUNT_LOW: rd = rx_count[15:0];
				OFS_RX_COUNT_HIGH: rd = rx_count[31:16];
				OFS_BAD_RX_COUNT_LOW: rd = bad_rx_count[15:0];
				OFS_BAD_RX_COUNT_HIGH: rd = bad_rx_count[31:16];
				OFS_TX_COUNT_LOW: rd = tx_count[15:0];
				OFS_TX_COUNT_HIGH: rd = tx_count[31:16];
				OFS_CONNECTED_INPUTS: rd = {14'h0000, curr_present, volt_present};
				OFS_ALARM_AND_OUTPUT_STATE: rd = state_word;
				OFS_VOLTAGE_READING: rd = voltage_reading;
				OFS_CURRENT_READING: rd = current_reading;
				OFS_VOLTAGE_HIGH_THRESHOLD: rd = volt_hi;
				OFS_VOLTAGE_LOW_THRESHOLD: rd = volt_lo;
				OFS_CURRENT_HIGH_THRESHOLD: rd = curr_hi;
				OFS_CURRENT_LOW_THRESHOLD: rd = curr_lo;
				OFS_VOLTAGE_ALARM_MODE: rd = volt_mode;
				OFS_CURRENT_ALARM_MODE: rd = curr_mode;
				OFS_VOLTAGE_RANGE_SELECT: rd = volt_range;
				OFS_CURRENT_RANGE_SELECT: rd = curr_range;
				OFS_OUTPUT_SOURCE_SELECT: rd = out_cfg;
				OFS_OUTPUT_THRESHOLD: rd = out_thr;
				OFS_OUTPUT_DEADBAND: rd = deadband;
				default: rd = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
			reg_ack <= 1'b0;
		end else begin
			reg_ack <= reg_req.valid;
			reg_rdata <= reg_req.valid ? rd : 16'h0000;
		end
	end
endmodule

`default_nettype wire

// file: analog_io_alarm_register_map_props.sv
// Assertion checker for the register port and reply timing of the alarm register bank.
`timescale 1ns/1ns
`default_nettype none
module analog_io_alarm_register_map_props import aio_alarm_pkg::*; #(
	parameter int MS_CYCLES = CYCLES_PER_MS,
	parameter logic [15:0] VERSION_CODE = 16'h0000
) (
	input wire logic clock, // System clock.
	input wire logic rst_n, // Reset, active low.
	input wire reg_req_t reg_req, // Register request.
	input wire logic [15:0] reg_rdata, // Read data.
	input wire logic reg_ack, // Answer pulse.
	input wire logic [7:0] node_address_strap, // Address switches.
	input wire logic reply_ready, // Reply frame ready.
	input wire logic reply_go // Reply start.
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire logic rd = reg_req.valid && !reg_req.write && !reg_req.bit_access;
	a_ack_follows_req: assert property (reg_req.valid |=> reg_ack) else $error("request not answered");
	a_no_stray_ack: assert property (!reg_req.valid |=> !reg_ack) else $error("answer without request");
	a_idle_rdata_zero: assert property (!reg_ack |-> reg_rdata == 16'h0000) else $error("data outside answer");
	a_unmapped_reads_zero: assert property (rd && reg_req.addr == 16'h0007 |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_version_read: assert property (rd && reg_req.addr == OFS_VERSION_AND_TYPE |=> reg_rdata == VERSION_CODE)
		else $error("version read wrong");
	a_node_addr_read: assert property (rd && reg_req.addr == OFS_NODE_ADDRESS && $stable(node_address_strap)
		|=> reg_rdata == {8'h00, $past(node_address_strap)}) else $error("node address read wrong");
	a_lowpass_in_range: assert property (rd && reg_req.addr == OFS_LOWPASS_SETTING
		|=> reg_rdata >= LOWPASS_MIN && reg_rdata <= LOWPASS_MAX) else $error("filter setting out of range");
	a_reply_go_pulse: assert property (reply_go |=> !reply_go) else $error("reply start too long");
	a_reply_not_early: assert property (reply_ready |=> !reply_go) else $error("reply started early");
	c_reply: cover property (reply_go);
	c_alarm_read: cover property (reg_ack && reg_rdata[POS_ANY_ALARM]);
	c_lowpass_read: cover property (rd && reg_req.addr == OFS_LOWPASS_SETTING);
endmodule
bind analog_io_alarm_register_map analog_io_alarm_register_map_props #(.MS_CYCLES(MS_CYCLES),
	.VERSION_CODE(VERSION_CODE)) props (.clock(clock), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.reg_ack(reg_ack), .node_address_strap(node_address_strap), .reply_ready(reply_ready), .reply_go(reply_go));
`default_nettype wire

// file: fieldbus_master_model.sv
// Fieldbus master model that issues word and bit accesses to the register bank.
`timescale 1ns/1ns
`default_nettype none
module fieldbus_master_model import aio_alarm_pkg::*; (
	input wire logic clock, // System clock.
	output var reg_req_t reg_req, // Request to the bank.
	input wire logic reg_ack, // Answer pulse.
	input wire logic [15:0] reg_rdata // Read data.
);
	initial reg_req = '0;
	// The request is held one cycle only, since every valid cycle counts as a new access.
	task automatic xfer(input logic w, input logic b, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] q);
		int n;
		@(negedge clock);
		reg_req <= '{valid: 1'b1, write: w, bit_access: b, addr: a, wdata: d};
		@(negedge clock);
		reg_req <= '0;
		n = 0;
		while (reg_ack !== 1'b1 && n < 8) begin
			@(posedge clock);
			#1;
			n++;
		end
		q = reg_rdata;
	endtask
endmodule
`default_nettype wire

// file: tb_analog_io_alarm_register_map.sv
// Self-checking testbench for the alarm register bank.
`timescale 1ns/1ns
`default_nettype none
module tb_analog_io_alarm_register_map;
	import aio_alarm_pkg::*;
	localparam logic [15:0] VER = 16'h5A3C; // Arbitrary identification value.
	logic clock = 1'b0, rst_n = 1'b0, vpin = 1'b1, cpin = 1'b1, reply_ready = 1'b0, reg_ack, reply_go, dout;
	logic signed [15:0] vraw = 16'sh0000, craw = 16'sh03E8;
	logic [15:0] reg_rdata, q;
	frame_events_t ev = '0;
	comm_config_t cfg;
	reg_req_t reg_req;
	int err_count = 0, num_checks = 0, cycles = 0, n;
	always #4 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			close_out();
		end
	end
	fieldbus_master_model bus (.clock(clock), .reg_req(reg_req), .reg_ack(reg_ack), .reg_rdata(reg_rdata));
	analog_io_alarm_register_map #(.MS_CYCLES(4), .VERSION_CODE(VER)) dut (.clock(clock), .rst_n(rst_n),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .node_address_strap(8'h2D),
		.sample_valid(1'b1), .voltage_raw(vraw), .current_raw(craw), .voltage_sense_pin(vpin),
		.current_sense_pin(cpin), .frame_events(ev), .reply_ready(reply_ready), .reply_go(reply_go),
		.comm_config(cfg), .digital_out(dout));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [15:0] a, input logic [15:0] d); bus.xfer(1'b1, 1'b0, a, d, q); endtask
	task bwr(input logic [15:0] a, input logic d); bus.xfer(1'b1, 1'b1, a, {15'h0000, d}, q); endtask
	task rd(input logic [15:0] a, input logic [15:0] e);
		bus.xfer(1'b0, 1'b0, a, 16'h0000, q);
		chk(q, e);
	endtask
	// New raw samples, then enough samples for the filter at setting 1 to settle.
	task drive(input logic signed [15:0] v, input logic signed [15:0] c);
		@(negedge clock);
		vraw = v;
		craw = c;
		repeat (40) @(negedge clock);
	endtask
	task pulse_reply;
		@(negedge clock);
		reply_ready = 1'b1;
		@(negedge clock);
		reply_ready = 1'b0;
		n = 1;
		while (reply_go !== 1'b1 && n < 40) begin
			@(posedge clock);
			#1;
			n++;
		end
	endtask
	task t_reset_filter;
		rd(OFS_CONNECTED_INPUTS, 16'h0000);
		rd(16'h0007, 16'h0000);
		rd(OFS_VERSION_AND_TYPE, VER);
		rd(OFS_NODE_ADDRESS, 16'h002D);
		chk(cfg.frame_format, RST_FRAME_FORMAT);
		rd(OFS_LOWPASS_SETTING, 16'h0001);
		wr(OFS_LOWPASS_SETTING, 16'h000B);
		rd(OFS_LOWPASS_SETTING, 16'h0001);
		wr(OFS_LOWPASS_SETTING, 16'h000A);
		rd(OFS_LOWPASS_SETTING, 16'h000A);
		wr(OFS_LOWPASS_SETTING, 16'h0001);
		$display("test reset_filter done");
	endtask
	task t_live_alarm;
		wr(OFS_VOLTAGE_RANGE_SELECT, VRANGE_0_10);
		wr(OFS_VOLTAGE_HIGH_THRESHOLD, 16'h03E8);
		drive(16'sh07D0, 16'sh03E8);
		rd(OFS_ALARM_AND_OUTPUT_STATE, 16'h0003);
		rd(OFS_CONNECTED_INPUTS, 16'h0001);
		drive(16'sh01F4, 16'sh03E8);
		rd(OFS_ALARM_AND_OUTPUT_STATE, 16'h0000);
		wr(OFS_VOLTAGE_LOW_THRESHOLD, 16'h0320);
		rd(OFS_ALARM_AND_OUTPUT_STATE, 16'h0003);
		wr(OFS_VOLTAGE_LOW_THRESHOLD, 16'h0000);
		$display("test live_alarm done");
	endtask
	task t_latched_alarm;
		wr(OFS_CURRENT_HIGH_THRESHOLD, 16'h7530);
		wr(OFS_CURRENT_LOW_THRESHOLD, 16'h1388);
		wr(OFS_CURRENT_ALARM_MODE, ALARM_LATCHED);
		wr(OFS_CURRENT_RANGE_SELECT, CRANGE_0_20);
		drive(16'sh01F4, 16'sh03E8);
		rd(OFS_ALARM_AND_OUTPUT_STATE, 16'h0006);
		rd(OFS_CONNECTED_INPUTS, 16'h0003);
		drive(16'sh01F4, 16'sh1F40);
		rd(OFS_ALARM_AND_OUTPUT_STATE, 16'h0006);
		bwr(OFS_CURRENT_ALARM_BIT, 1'b0);
		rd(OFS_ALARM_AND_OUTPUT_STATE, 16'h0000);
		wr(OFS_CURRENT_HIGH_THRESHOLD, 16'h03E8);
		rd(OFS_ALARM_AND_OUTPUT_STATE, 16'h0006);
		wr(OFS_CURRENT_ALARM_MODE, ALARM_LIVE);
		wr(OFS_CURRENT_HIGH_THRESHOLD, 16'h7530);
		$display("test latched_alarm done");
	endtask
	task t_output;
		wr(OFS_OUTPUT_THRESHOLD, 16'h0064);
		wr(OFS_OUTPUT_SOURCE_SELECT, 16'h0101);
		repeat (3) @(negedge clock);
		chk({15'h0000, dout}, 16'h0001);
		rd(OFS_ALARM_AND_OUTPUT_STATE, 16'h0008);
		wr(OFS_OUTPUT_DEADBAND, 16'h00C8);
		wr(OFS_OUTPUT_THRESHOLD, 16'h0258);
		repeat (3) @(negedge clock);
		chk({15'h0000, dout}, 16'h0001);
		wr(OFS_OUTPUT_THRESHOLD, 16'h0064);
		wr(OFS_OUTPUT_SOURCE_SELECT, 16'h0201);
		repeat (3) @(negedge clock);
		chk({15'h0000, dout}, 16'h0000);
		wr(OFS_OUTPUT_SOURCE_SELECT, 16'h0102);
		repeat (3) @(negedge clock);
		chk({15'h0000, dout}, 16'h0001);
		wr(OFS_OUTPUT_SOURCE_SELECT, 16'h0000);
		bwr(OFS_OUTPUT_STATE_BIT, 1'b0);
		repeat (3) @(negedge clock);
		chk({15'h0000, dout}, 16'h0000);
		$display("test output done");
	endtask
	task t_counters_reply;
		repeat (3) begin
			@(negedge clock);
			ev.rx_frame = 1'b1;
			@(negedge clock);
			ev.rx_frame = 1'b0;
		end
		rd(OFS_RX_COUNT_LOW, 16'h0003);
		wr(OFS_RX_COUNT_HIGH, 16'h1234);
		rd(OFS_RX_COUNT_HIGH, 16'h1234);
		pulse_reply();
		chk(n[15:0], 16'h0002);
		wr(OFS_REPLY_DELAY, 16'h0001);
		pulse_reply();
		chk({15'h0000, n >= 6 && n <= 7}, 16'h0001);
		$display("test counters_reply done");
	endtask
	task close_out;
		$display("checks=%0d mismatches=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clock);
		rst_n = 1'b1;
		t_reset_filter();
		t_live_alarm();
		t_latched_alarm();
		t_output();
		t_counters_reply();
		close_out();
	end
endmodule
`default_nettype wire
